// ==== tb_vccd_top.sv ====
// self-checking bench for the calibration and divider block
`timescale 1ns/1ps
`include "vccd_cfg.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_vccd_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ref_en = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, reference_input, ext_tick, osc_tick, lv;
  logic chan0_out, chan1_out, chan2_out, chan3_out, chan4_out;
  logic dist_sync, loop_closed, cal_busy;
  logic [31:0] hrdata;
  logic [4:0] chans;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0, hi, lo;
  assign chans = {chan4_out, chan3_out, chan2_out, chan1_out, chan0_out};
  vccd_top uut (.hready(hreadyout), .*);
  vccd_src_model u_src (.*);
  // =====================================================================
  // clock and cycle count
  initial forever #20 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  task end_sim;
    $display("checks=%0d errors=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // =====================================================================
  // bus master: hold each phase until ready is seen high at an edge
  task automatic ahb(input logic wr, input logic [9:0] idx,
      input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'h0};
    do @(negedge hclk); while (hreadyout !== 1'b1 && k++ < 50);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge hclk); while (hreadyout !== 1'b1 && k++ < 50);
    if (k > 49) bad_count++;
    rd = hrdata;
    @(posedge hclk);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, idx, d, x);
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, idx, 32'h0, x);
    `CHK(x & m, e)
  endtask
  // one high and one low span of a channel, in clock cycles
  task automatic meas(input int c, input int eh, input int el);
    int k;
    k = 0;
    while (chans[c] !== 1'b0 && k++ < 400) @(negedge hclk);
    while (chans[c] !== 1'b1 && k++ < 800) @(negedge hclk);
    hi = 0;
    lo = 0;
    while (chans[c] === 1'b1 && hi++ < 400) @(negedge hclk);
    while (chans[c] === 1'b0 && lo++ < 400) @(negedge hclk);
    `CHK(hi, eh)
    `CHK(lo, el)
  endtask
  task automatic upd_src(input logic [31:0] s);
    wr(`VCCD_IDX_SRC_SEL, s);
    wr(`VCCD_IDX_UPDATE, 32'h1);
    repeat (4) @(negedge hclk);
  endtask
  // =====================================================================
  // watchdog sized well above the expected run of about 40000 cycles
  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    end_sim;
  end
  // =====================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`VCCD_IDX_SRC_SEL, 32'h3, 32'h1);
    wr(10'h0ff, 32'hff);
    rd_chk(10'h0ff, 32'hffffffff, 32'h0);
    wr(`VCCD_IDX_DIV_BASE, 32'hc021);
    wr(`VCCD_IDX_DIV_BASE + 10'h2, 32'h0021);
    wr(`VCCD_IDX_DIV_BASE + 10'h5, 32'h2000);
    wr(`VCCD_IDX_CAL_CTRL, 32'h1);
    wr(`VCCD_IDX_UPDATE, 32'h1);
    repeat (4) @(negedge hclk);
    t0 = cyc;
    `CHK(cal_busy, 1'b1)
    `CHK(loop_closed, 1'b0)
    rd_chk(`VCCD_IDX_READBACK, 32'h40, 32'h0);
    `CHK(chans[0], 1'b1)
    `CHK(chans[2], 1'b0)
    // a 2000-cycle loss of reference must stretch the run by as much
    ref_en <= 1'b0;
    repeat (2000) @(negedge hclk);
    ref_en <= 1'b1;
    while (cal_busy === 1'b1 && cyc - t0 < 40000) @(negedge hclk);
    `CHK(cyc - t0 > 37190 && cyc - t0 < 37225, 1'b1)
    `CHK(loop_closed, 1'b1)
    rd_chk(`VCCD_IDX_READBACK, 32'h40, 32'h40);
    meas(0, 6, 9);
    meas(2, 7, 8);
    meas(1, 3, 3);
    meas(3, 6, 6);
    meas(4, 3, 3);
    wr(`VCCD_IDX_PREDIV, 32'h3);
    upd_src(32'h0);
    `CHK(cal_busy, 1'b0)
    meas(1, 9, 9);
    upd_src(32'h2);
    meas(1, 12, 12);
    upd_src(32'h3);
    lv = chans[1];
    lo = 0;
    repeat (60) @(negedge hclk) lo += (chans[1] !== lv);
    `CHK(lo, 0)
    wr(`VCCD_IDX_RDIV, 32'h2);
    wr(`VCCD_IDX_CAL_CTRL, 32'h0);
    wr(`VCCD_IDX_UPDATE, 32'h1);
    wr(`VCCD_IDX_CAL_CTRL, 32'h1);
    wr(`VCCD_IDX_UPDATE, 32'h1);
    repeat (4) @(negedge hclk);
    `CHK(cal_busy, 1'b1)
    rd_chk(`VCCD_IDX_READBACK, 32'h40, 32'h0);
    hresetn <= 1'b0;
    repeat (3) @(negedge hclk);
    `CHK(cal_busy, 1'b0)
    `CHK(loop_closed, 1'b1)
    // second release: done cleared, a fresh start needs no clear first
    @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`VCCD_IDX_READBACK, 32'h40, 32'h0);
    wr(`VCCD_IDX_CAL_CTRL, 32'h1);
    wr(`VCCD_IDX_UPDATE, 32'h1);
    repeat (4) @(negedge hclk);
    `CHK(cal_busy, 1'b1)
    end_sim;
  end
endmodule

// ==== vccd_cfg.svh ====
// constants for the oscillator calibration and clock divider block
// =====================================================================
`ifndef VCCD_CFG_SVH
`define VCCD_CFG_SVH

// =====================================================================
// register indices, byte address is four times the index
`define VCCD_IDX_CAL_CTRL 10'h018
`define VCCD_IDX_READBACK 10'h01f
`define VCCD_IDX_PREDIV 10'h1e0
`define VCCD_IDX_SRC_SEL 10'h1e1
`define VCCD_IDX_UPDATE 10'h232
`define VCCD_IDX_DIV_BASE 10'h300
`define VCCD_IDX_RDIV 10'h310

// =====================================================================
// field positions and reset values
`define VCCD_CAL_START_BIT 0
`define VCCD_CAL_DONE_BIT 6
`define VCCD_NUM_DIV 7
`define VCCD_RST_CAL_CTRL 3'h0
`define VCCD_RST_SRC_SEL 2'h1
`define VCCD_RST_PREDIV 3'h2
`define VCCD_RST_RDIV 14'h0001
`define VCCD_RST_DIV_CFG 16'h0000
`define VCCD_PREDIV_MIN 3'h2
`define VCCD_PREDIV_MAX 3'h6

// =====================================================================
// timing counts
`define VCCD_CAL_CYCLES 13'd4400

`endif

// ==== vccd_chan_div.sv ====
// one channel divider stage with phase offset, start level and dcc
`timescale 1ns/1ps
`include "vccd_cfg.svh"
module vccd_chan_div (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sync,
  input wire logic in_tick,
  input wire logic [3:0] high_cnt,
  input wire logic [3:0] low_cnt,
  input wire logic [4:0] phase,
  input wire logic bypass,
  input wire logic dcc_off,
  input wire logic start_high,
  output logic out_level,
  output logic out_rise
);
  import vccd_pkg::*;
  logic level, waiting;
  logic [4:0] cnt;
  logic next_level, next_waiting, next_fall_hold;
  logic [4:0] next_cnt;
  logic next_out_level, next_out_rise;
  logic [4:0] span;
  logic dcc_on;

  // largest offset is one less than the division
  assign span = 5'(high_cnt) + 5'(low_cnt) + 5'h01;
  // correction only applies to odd ratios set as low = high + 1
  assign dcc_on = !dcc_off && (5'(low_cnt) == 5'(high_cnt) + 5'h01);

  // =====================================================================
  // phase counting and high/low sequencing
  always_comb begin
    next_level = level;
    next_waiting = waiting;
    next_cnt = cnt;
    next_fall_hold = 1'b0;
    next_out_rise = 1'b0;
    if (sync) begin
      next_level = start_high;
      next_waiting = 1'b1;
      next_cnt = (phase > span) ? span : phase;
    end else if (in_tick) begin
      if (waiting) begin
        if (cnt == 5'h00) begin
          next_waiting = 1'b0;
          next_cnt = level ? 5'(high_cnt) : 5'(low_cnt);
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end else if (cnt == 5'h00) begin
        next_level = !level;
        next_cnt = level ? 5'(low_cnt) : 5'(high_cnt);
        next_out_rise = !level;
        next_fall_hold = level && dcc_on;
      end else begin
        next_cnt = cnt - 5'h01;
      end
    end
    // bypass is ratio one: the input tick is the output
    if (bypass) begin
      next_out_level = sync ? start_high : in_tick;
      next_out_rise = in_tick && !sync;
    end else begin
      // falling edge held one clock cycle late to even the duty
      next_out_level = next_level || next_fall_hold;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level <= 1'b0;
      waiting <= 1'b1;
      cnt <= 5'h00;
      out_level <= 1'b0;
      out_rise <= 1'b0;
    end else begin
      level <= next_level;
      waiting <= next_waiting;
      cnt <= next_cnt;
      out_level <= next_out_level;
      out_rise <= next_out_rise;
    end
  end
endmodule

// ==== vccd_pkg.sv ====
// types shared by the oscillator calibration and clock divider block
package vccd_pkg;
  typedef enum logic [2:0] {
    VCCD_IDLE, VCCD_SYNC, VCCD_CAL, VCCD_RELEASE, VCCD_CLOSE
  } vccd_cal_state_t;
  typedef enum logic [1:0] {
    VCCD_SRC_EXT_PREDIV = 2'h0,
    VCCD_SRC_EXT_DIRECT = 2'h1,
    VCCD_SRC_OSC_PREDIV = 2'h2,
    VCCD_SRC_BAD = 2'h3
  } vccd_src_t;
endpackage

// ==== vccd_src_model.sv ====
// clock source model: reference pin plus external and oscillator ticks
`timescale 1ns/1ps
module vccd_src_model (
  input wire logic hclk,
  input wire logic ref_en,
  output logic reference_input,
  output logic ext_tick,
  output logic osc_tick
);
  logic [1:0] ref_cnt = 2'h0;
  logic [1:0] ext_cnt = 2'h0;
  logic [1:0] osc_cnt = 2'h0;
  // =====================================================================
  // free counters; ticks keep at least two cycles apart as required
  always @(posedge hclk) begin
    ref_cnt <= ref_cnt + 2'h1;
    ext_cnt <= (ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
    osc_cnt <= osc_cnt + 2'h1;
  end
  // a lost reference parks low, so calibration must stall
  assign reference_input = ref_en & ref_cnt[1];
  assign ext_tick = (ext_cnt == 2'h0);
  assign osc_tick = (osc_cnt == 2'h0);
endmodule

// ==== vccd_tick_div.sv ====
// event divider: one output tick for every ratio input ticks
`timescale 1ns/1ps
module vccd_tick_div (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic in_tick,
  input wire logic [13:0] ratio,
  output logic out_tick
);
  import vccd_pkg::*;
  logic [13:0] cnt;
  logic [13:0] next_cnt;
  logic next_out_tick;

  // =====================================================================
  // counter, a ratio of zero or one passes every tick
  always_comb begin
    next_cnt = cnt;
    next_out_tick = 1'b0;
    if (clear) begin
      next_cnt = 14'h0000;
    end else if (in_tick) begin
      if (ratio <= 14'h0001 || cnt >= ratio - 14'h0001) begin
        next_cnt = 14'h0000;
        next_out_tick = 1'b1;
      end else begin
        next_cnt = cnt + 14'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 14'h0000;
      out_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      out_tick <= next_out_tick;
    end
  end
endmodule

// ==== vccd_top.sv ====
// calibration sequencer, clock source selection and channel dividers
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "vccd_cfg.svh"
module vccd_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic reference_input,
  input wire logic ext_tick,
  input wire logic osc_tick,
  output logic chan0_out,
  output logic chan1_out,
  output logic chan2_out,
  output logic chan3_out,
  output logic chan4_out,
  output logic dist_sync,
  output logic loop_closed,
  output logic cal_busy
);
  import vccd_pkg::*;

  // =====================================================================
  // helper functions

  // register index of a byte address, all-ones when any address bit above bit 11 is set
  function automatic logic [9:0] reg_index(input logic [31:0] a);
    logic [9:0] idx;
    idx = a[11:2];
    if (a[31:12] != 20'h00000) begin
      idx = 10'h3ff;
    end
    return idx;
  endfunction

  // divider config word: [3:0] high, [7:4] low, [12:8] phase,
  // [13] bypass, [14] dcc off, [15] start high
  function automatic logic [15:0] cfg_word(input logic [31:0] d);
    return d[15:0];
  endfunction

  // =====================================================================
  // bus data phase state
  logic dp_valid, dp_write, rd_done, wr_en, upd;
  logic [9:0] dp_idx, next_dp_idx;
  logic next_dp_valid, next_dp_write, next_rd_done;
  logic [31:0] next_hrdata, rd_value;

  // =====================================================================
  // staged and active registers
  logic [2:0] cal_stage, cal_act, next_cal_stage, next_cal_act;
  logic [1:0] src_stage, src_act, next_src_stage, next_src_act;
  logic [2:0] prediv_stage, prediv_act, next_prediv_stage, next_prediv_act;
  logic [13:0] rdiv_stage, rdiv_act, next_rdiv_stage, next_rdiv_act;
  logic [15:0] div_stage [`VCCD_NUM_DIV], div_act [`VCCD_NUM_DIV];
  logic [15:0] next_div_stage [`VCCD_NUM_DIV], next_div_act [`VCCD_NUM_DIV];

  // =====================================================================
  // reference synchroniser and calibration state
  logic ref_s1, ref_s2, ref_s3, ref_level, next_ref_level, ref_rise;
  vccd_cal_state_t state, next_state;
  logic [12:0] cal_cnt, next_cal_cnt;
  logic cal_done, next_cal_done, cal_go, pfd_tick, cal_tick;
  logic [13:0] cal_ratio;

  // =====================================================================
  // distribution signals
  logic prediv_ok, prediv_tick, dist_tick;
  logic [`VCCD_NUM_DIV-1:0] div_level, div_rise, div_in;

  // =====================================================================
  // ahb-lite slave: writes take no wait, reads one wait state
  assign wr_en = dp_valid && dp_write;
  assign hresp = 1'b0;
  // the wait lets a write just before a read land before the read
  assign hreadyout = !(dp_valid && !dp_write) || rd_done;

  always_comb begin
    next_dp_valid = dp_valid;
    next_dp_write = dp_write;
    next_dp_idx = dp_idx;
    if (hready) begin
      next_dp_valid = hsel && htrans[1];
      next_dp_write = hwrite;
      next_dp_idx = reg_index(haddr);
    end
    next_rd_done = dp_valid && !dp_write && !rd_done;
    next_hrdata = hrdata;
    if (dp_valid && !dp_write && !rd_done) begin
      next_hrdata = rd_value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx <= 10'h000;
      rd_done <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_idx <= next_dp_idx;
      rd_done <= next_rd_done;
      hrdata <= next_hrdata;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_value = 32'h00000000;
    case (dp_idx)
      `VCCD_IDX_CAL_CTRL: rd_value = {29'h0, cal_stage};
      `VCCD_IDX_READBACK: rd_value[`VCCD_CAL_DONE_BIT] = cal_done;
      `VCCD_IDX_PREDIV: rd_value = {29'h0, prediv_stage};
      `VCCD_IDX_SRC_SEL: rd_value = {30'h0, src_stage};
      `VCCD_IDX_RDIV: rd_value = {18'h0, rdiv_stage};
      default: begin
        if (dp_idx >= `VCCD_IDX_DIV_BASE &&
            dp_idx < `VCCD_IDX_DIV_BASE + 10'(`VCCD_NUM_DIV)) begin
          rd_value = {16'h0, div_stage[3'(dp_idx - `VCCD_IDX_DIV_BASE)]};
        end
      end
    endcase
  end

  // =====================================================================
  // register file: writes go to staging, the update strobe copies them
  assign upd = wr_en && dp_idx == `VCCD_IDX_UPDATE && hwdata[0];
  // start only on a 0 to 1 change of the active start bit
  assign cal_go = upd && cal_stage[`VCCD_CAL_START_BIT] &&
                  !cal_act[`VCCD_CAL_START_BIT];

  always_comb begin
    next_cal_stage = cal_stage;
    next_src_stage = src_stage;
    next_prediv_stage = prediv_stage;
    next_rdiv_stage = rdiv_stage;
    next_cal_act = cal_act;
    next_src_act = src_act;
    next_prediv_act = prediv_act;
    next_rdiv_act = rdiv_act;
    for (int i = 0; i < `VCCD_NUM_DIV; i++) begin
      next_div_stage[i] = div_stage[i];
      next_div_act[i] = div_act[i];
    end
    if (wr_en) begin
      case (dp_idx)
        `VCCD_IDX_CAL_CTRL: next_cal_stage = hwdata[2:0];
        `VCCD_IDX_PREDIV: next_prediv_stage = hwdata[2:0];
        `VCCD_IDX_SRC_SEL: next_src_stage = hwdata[1:0];
        `VCCD_IDX_RDIV: next_rdiv_stage = hwdata[13:0];
        default: begin
          for (int i = 0; i < `VCCD_NUM_DIV; i++) begin
            if (dp_idx == `VCCD_IDX_DIV_BASE + 10'(i)) begin
              next_div_stage[i] = cfg_word(hwdata);
            end
          end
        end
      endcase
    end
    if (upd) begin
      next_cal_act = cal_stage;
      next_src_act = src_stage;
      next_prediv_act = prediv_stage;
      next_rdiv_act = rdiv_stage;
      for (int i = 0; i < `VCCD_NUM_DIV; i++) begin
        next_div_act[i] = div_stage[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_stage <= `VCCD_RST_CAL_CTRL;
      src_stage <= `VCCD_RST_SRC_SEL;
      prediv_stage <= `VCCD_RST_PREDIV;
      rdiv_stage <= `VCCD_RST_RDIV;
      cal_act <= `VCCD_RST_CAL_CTRL;
      src_act <= `VCCD_RST_SRC_SEL;
      prediv_act <= `VCCD_RST_PREDIV;
      rdiv_act <= `VCCD_RST_RDIV;
      for (int i = 0; i < `VCCD_NUM_DIV; i++) begin
        div_stage[i] <= `VCCD_RST_DIV_CFG;
        div_act[i] <= `VCCD_RST_DIV_CFG;
      end
    end else begin
      cal_stage <= next_cal_stage;
      src_stage <= next_src_stage;
      prediv_stage <= next_prediv_stage;
      rdiv_stage <= next_rdiv_stage;
      cal_act <= next_cal_act;
      src_act <= next_src_act;
      prediv_act <= next_prediv_act;
      rdiv_act <= next_rdiv_act;
      for (int i = 0; i < `VCCD_NUM_DIV; i++) begin
        div_stage[i] <= next_div_stage[i];
        div_act[i] <= next_div_act[i];
      end
    end
  end

  // =====================================================================
  // reference pin: three flops, edge counts once stages two and three
  // agree, so a glitch shorter than a clock never reaches the counters
  assign ref_rise = (ref_s2 == ref_s3) && ref_s3 && !ref_level;

  always_comb begin
    next_ref_level = (ref_s2 == ref_s3) ? ref_s3 : ref_level;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      ref_level <= 1'b0;
    end else begin
      ref_s1 <= reference_input;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      ref_level <= next_ref_level;
    end
  end

  // =====================================================================
  // calibration clock: reference edges over r, then over cal divider
  assign cal_ratio = 14'h0002 << cal_act[2:1];

  vccd_tick_div u_rdiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(1'b0),
    .in_tick(ref_rise),
    .ratio(rdiv_act),
    .out_tick(pfd_tick)
  );

  vccd_tick_div u_caldiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(state != VCCD_CAL),
    .in_tick(pfd_tick),
    .ratio(cal_ratio),
    .out_tick(cal_tick)
  );

  // =====================================================================
  // calibration sequencer: sync, count, release, close the loop
  always_comb begin
    next_state = state;
    next_cal_cnt = cal_cnt;
    next_cal_done = cal_done;
    case (state)
      VCCD_IDLE: begin
        if (cal_go) begin
          next_state = VCCD_SYNC;
          next_cal_done = 1'b0;
        end
      end
      VCCD_SYNC: begin
        next_state = VCCD_CAL;
        next_cal_cnt = 13'h0000;
      end
      VCCD_CAL: begin
        // no reference edges means no progress
        if (cal_tick) begin
          if (cal_cnt == `VCCD_CAL_CYCLES - 13'h0001) begin
            next_state = VCCD_RELEASE;
          end else begin
            next_cal_cnt = cal_cnt + 13'h0001;
          end
        end
      end
      VCCD_RELEASE: next_state = VCCD_CLOSE;
      VCCD_CLOSE: begin
        next_state = VCCD_IDLE;
        next_cal_done = 1'b1;
      end
      default: next_state = VCCD_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= VCCD_IDLE;
      cal_cnt <= 13'h0000;
      cal_done <= 1'b0;
      dist_sync <= 1'b0;
      loop_closed <= 1'b1;
      cal_busy <= 1'b0;
    end else begin
      state <= next_state;
      cal_cnt <= next_cal_cnt;
      cal_done <= next_cal_done;
      // outputs held static from sync until the count ends
      dist_sync <= next_state == VCCD_SYNC ||
                   next_state == VCCD_CAL;
      // loop closes only after the sync has been released
      loop_closed <= next_state == VCCD_IDLE;
      cal_busy <= next_state != VCCD_IDLE;
    end
  end

  // =====================================================================
  // clock source and pre-divider; code 11 feeds nothing
  assign prediv_ok = prediv_act >= `VCCD_PREDIV_MIN &&
                     prediv_act <= `VCCD_PREDIV_MAX;

  vccd_tick_div u_prediv (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(!prediv_ok),
    .in_tick(src_act == VCCD_SRC_OSC_PREDIV ? osc_tick :
             src_act == VCCD_SRC_EXT_PREDIV ? ext_tick : 1'b0),
    .ratio({11'h000, prediv_act}),
    .out_tick(prediv_tick)
  );

  // the oscillator has no path around the pre-divider
  always_comb begin
    case (vccd_src_t'(src_act))
      VCCD_SRC_EXT_PREDIV: dist_tick = prediv_tick && prediv_ok;
      VCCD_SRC_EXT_DIRECT: dist_tick = ext_tick;
      VCCD_SRC_OSC_PREDIV: dist_tick = prediv_tick && prediv_ok;
      default: dist_tick = 1'b0;
    endcase
  end

  // =====================================================================
  // seven divider stages: 0..2 single, 3/4 and 5/6 cascaded pairs
  assign div_in = {div_rise[5], dist_tick, div_rise[3],
                   {4{dist_tick}}};

  for (genvar g = 0; g < `VCCD_NUM_DIV; g++) begin : g_div
    vccd_chan_div u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .sync(dist_sync),
      .in_tick(div_in[g]),
      .high_cnt(div_act[g][3:0]),
      .low_cnt(div_act[g][7:4]),
      .phase(div_act[g][12:8]),
      .bypass(div_act[g][13]),
      .dcc_off(div_act[g][14]),
      .start_high(div_act[g][15]),
      .out_level(div_level[g]),
      .out_rise(div_rise[g])
    );
  end

  // channel outputs, cascaded channels take the second stage
  assign chan0_out = div_level[0];
  assign chan1_out = div_level[1];
  assign chan2_out = div_level[2];
  assign chan3_out = div_level[4];
  assign chan4_out = div_level[6];
endmodule

// ==== vccd_top_assertions.sv ====
// port-level checker for the calibration sequencer and dividers
`timescale 1ns/1ps
`include "vccd_cfg.svh"
module vccd_top_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic chan0_out,
  input wire logic chan1_out,
  input wire logic chan2_out,
  input wire logic chan3_out,
  input wire logic chan4_out,
  input wire logic dist_sync,
  input wire logic loop_closed,
  input wire logic cal_busy
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic upd_ap;
  logic upd_hit;
  logic [15:0] busy_cnt;
  logic [4:0] chans;
  assign chans = {chan4_out, chan3_out, chan2_out, chan1_out, chan0_out};
  // =====================================================================
  // helper: remember update strobes and how long calibration has run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upd_ap <= 1'b0;
      upd_hit <= 1'b0;
      busy_cnt <= 16'h0000;
    end else begin
      upd_ap <= hsel && htrans[1] && hready && hwrite &&
        haddr == {20'h0, `VCCD_IDX_UPDATE, 2'h0};
      upd_hit <= upd_ap && hwdata[0];
      busy_cnt <= cal_busy ? busy_cnt + 16'h0001 : 16'h0000;
    end
  end
  // =====================================================================
  // sequencer, channel and bus relations
  chk_start_sync: assert property ($rose(cal_busy) |-> dist_sync && !loop_closed)
    else $error("calibration started without sync");
  chk_sync_in_cal: assert property (dist_sync |-> cal_busy)
    else $error("sync held outside calibration");
  chk_sync_hold: assert property ($rose(dist_sync) |-> dist_sync [*8])
    else $error("sync released too early");
  chk_cal_length: assert property ($fell(cal_busy) |-> busy_cnt >= 16'h44c0)
    else $error("calibration finished too soon");
  chk_busy_open: assert property (cal_busy |-> !loop_closed)
    else $error("loop closed during calibration");
  chk_release_order: assert property ($fell(dist_sync) |-> !loop_closed ##[1:2] loop_closed)
    else $error("loop not closed after sync release");
  chk_close_idle: assert property ($rose(loop_closed) |-> !cal_busy && !dist_sync)
    else $error("loop closed before sequence end");
  chk_chan_static: assert property (dist_sync && $past(dist_sync) && $past(dist_sync, 2) |-> $stable(chans))
    else $error("channel toggled during sync");
  chk_manual_start: assert property ($rose(cal_busy) |-> upd_hit)
    else $error("calibration started without update strobe");
  chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  // the slave never signals an error response
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  cover property ($rose(cal_busy));
  cover property ($rose(loop_closed));
  cover property ($fell(dist_sync));
endmodule
bind vccd_top vccd_top_assertions u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .chan0_out,
  .chan1_out, .chan2_out, .chan3_out, .chan4_out, .dist_sync, .loop_closed,
  .cal_busy);
